// ==== src/dsss_pkg.sv ====
// Constants and carrier types for the drive start/stop sequencer.
// Assumes a 25 MHz system clock and a classic Wishbone master with 32-bit data.
package dsss_pkg;

   localparam int DW = 16;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_NRM_MS   = 8'h04;
   localparam logic [7:0] OFS_QCK_MS   = 8'h08;
   localparam logic [7:0] OFS_QCK_CAP  = 8'h0c;
   localparam logic [7:0] OFS_ZERO_THR = 8'h10;
   localparam logic [7:0] OFS_INCH1    = 8'h14;
   localparam logic [7:0] OFS_INCH2    = 8'h18;
   localparam logic [7:0] OFS_CRAWL    = 8'h1c;
   localparam logic [7:0] OFS_RUN_SPD  = 8'h20;
   localparam logic [7:0] OFS_HOLD_MS  = 8'h24;
   localparam logic [7:0] OFS_STATUS   = 8'h28;
   localparam logic [7:0] OFS_DEMAND   = 8'h2c;

   // Control register bit positions
   localparam int CTRL_HOLD_ZERO  = 0;
   localparam int CTRL_INCH_SEL   = 1;
   localparam int CTRL_TRIP_RESET = 2;
   localparam int CTRL_REVERSE    = 3;

   // Values after reset
   localparam logic [15:0] RST_NRM_MS   = 16'h03e8;
   localparam logic [15:0] RST_QCK_MS   = 16'h01f4;
   localparam logic [15:0] RST_QCK_CAP  = 16'h4000;
   localparam logic [15:0] RST_ZERO_THR = 16'h0080;
   localparam logic [15:0] RST_INCH1    = 16'h0800;
   localparam logic [15:0] RST_INCH2    = 16'h1000;
   localparam logic [15:0] RST_CRAWL    = 16'h0400;
   localparam logic [15:0] RST_RUN_SPD  = 16'h0000;
   localparam logic [15:0] RST_HOLD_MS  = 16'h00c8;
   localparam logic [15:0] FULL_CAP     = 16'hffff;

   // Timing: one millisecond of timer tick
   localparam int TICK_NS    = 1000000;
   localparam int CLK_NS     = 40;
   localparam int CYC_PER_MS = TICK_NS / CLK_NS;

   typedef enum logic [8:0] {
      ST_IDLE     = 9'h001,
      ST_RUN      = 9'h002,
      ST_CRAWL    = 9'h004,
      ST_JOG      = 9'h008,
      ST_JOG_HOLD = 9'h010,
      ST_STOP_NRM = 9'h020,
      ST_STOP_QCK = 9'h040,
      ST_COAST    = 9'h080,
      ST_TRIP     = 9'h100
   } dsss_state_t;

   typedef struct packed {
      logic enableTerminal;
      logic startRunTerminal;
      logic jogModeTerminal;
      logic controlledStopTerminal;
      logic freewheelStopTerminal;
   } dsss_term_t;

   typedef struct packed {
      logic [15:0] speedDemand;
      logic [15:0] currentCap;
      logic        reverseDir;
      logic        quench;
      logic        contactorClose;
      logic        loopsInhibit;
      logic        tripLatched;
   } dsss_drive_t;

   typedef struct packed {
      logic        holdZero;
      logic        inchSel;
      logic        reverseSel;
      logic [15:0] normalMs;
      logic [15:0] quickMs;
      logic [15:0] quickCap;
      logic [15:0] zeroThresh;
      logic [15:0] inch1;
      logic [15:0] inch2;
      logic [15:0] crawl;
      logic [15:0] runSpeed;
      logic [15:0] holdoffMs;
   } dsss_cfg_t;

   typedef struct packed {
      logic [31:0] acc;
      logic [15:0] startValue;
      logic [15:0] value;
   } dsss_ramp_t;

endpackage

// ==== src/dsss_stop_ramp.sv ====
// Linear ramp from a loaded value down to zero over a given number of cycles.
// Assumes the duration stays stable while the ramp runs.
`timescale 1ns/100ps
`default_nettype none
module dsss_stop_ramp
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   // Control
   input  wire logic        load,
   input  wire logic [15:0] startValue,
   input  wire logic [31:0] durCycles,
   // Result
   output logic [15:0]      value,
   output logic             atZero
);

   dsss_pkg::dsss_ramp_t s;
   dsss_pkg::dsss_ramp_t next_s;
   logic [31:0]          sum;

   // Error accumulator: one LSB step each time the start value adds up to the duration.
   // A start value larger than the duration cannot step faster than one LSB a cycle;
   // the elapsed timer then finishes the stop.
   always_comb
   begin
      next_s = s;
      sum    = s.acc + {16'h0000, s.startValue};
      if (load)
      begin
         next_s.value      = startValue;
         next_s.startValue = startValue;
         next_s.acc        = 32'h0000_0000;
      end
      else if (s.value != 16'h0000)
      begin
         if (sum >= durCycles)
         begin
            next_s.value = s.value - 16'h0001;
            next_s.acc   = sum - durCycles;
         end
         else
         begin
            next_s.acc = sum;
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         s <= '0;
      else
         s <= next_s;
   end

   assign value  = s.value;
   assign atZero = (s.value == 16'h0000);

endmodule // dsss_stop_ramp
`default_nettype wire

// ==== src/dsss_sequencer.sv ====
// Start, stop and run-mode sequencer for a DC motor drive, Wishbone register slave.
// Assumes terminal, alarm and trip inputs are already synchronous to sys_clk.
`timescale 1ns/100ps
`default_nettype none
module dsss_sequencer
#(
   parameter int CYC_PER_MS = dsss_pkg::CYC_PER_MS
)
(
   // Clock and reset
   input  wire logic                sys_clk,
   input  wire logic                reset_n,
   // Wishbone slave
   input  wire logic                wb_cyc_i,
   input  wire logic                wb_stb_i,
   input  wire logic                wb_we_i,
   input  wire logic [7:0]          wb_adr_i,
   input  wire logic [3:0]          wb_sel_i,
   input  wire logic [31:0]         wb_dat_i,
   output logic [31:0]              wb_dat_o,
   output logic                     wb_ack_o,
   // Terminals and drive status
   input  wire dsss_pkg::dsss_term_t terminals,
   input  wire logic                alarmActive,
   input  wire logic                tripCondition,
   input  wire logic [15:0]         measuredSpeed,
   // Drive commands
   output dsss_pkg::dsss_drive_t    drive
);

   typedef struct packed {
      dsss_pkg::dsss_state_t state;
      dsss_pkg::dsss_cfg_t   cfg;
      dsss_pkg::dsss_drive_t drive;
      logic                  tripReset;
      logic                  wbAck;
      logic [31:0]           wbDat;
      logic [15:0]           msDiv;
      logic [15:0]           msCount;
   } dsss_seq_t;

   localparam logic [15:0] MS_LAST = 16'(CYC_PER_MS - 1);

   dsss_seq_t   s;
   dsss_seq_t   next_s;
   logic        access;
   logic        startOk;
   logic        jogOk;
   logic        crawlOk;
   logic        rampLoad;
   logic [15:0] rampValue;
   logic        rampAtZero;
   logic [15:0] rampMs;
   logic [31:0] rampCycles;
   logic [31:0] rdData;

   function automatic logic [15:0] laneWrite(input logic [15:0] old,
                                             input logic [15:0] wr,
                                             input logic [1:0]  sel);
      logic [15:0] r;
      r       = old;
      if (sel[0])
         r[7:0] = wr[7:0];
      if (sel[1])
         r[15:8] = wr[15:8];
      return r;
   endfunction

   // Quick ramp duration applies once a controlled stop is in force
   assign rampMs     = (next_s.state == dsss_pkg::ST_STOP_QCK) ? s.cfg.quickMs : s.cfg.normalMs;
   assign rampCycles = 32'(rampMs) * 32'(CYC_PER_MS);

   dsss_stop_ramp u_ramp
   (
      .sys_clk    (sys_clk),
      .reset_n    (reset_n),
      .load       (rampLoad),
      .startValue (s.drive.speedDemand),
      .durCycles  (rampCycles),
      .value      (rampValue),
      .atZero     (rampAtZero)
   );

   // Start qualifiers
   always_comb
   begin
      startOk = terminals.enableTerminal && terminals.startRunTerminal
                && !terminals.jogModeTerminal && !alarmActive
                && terminals.controlledStopTerminal
                && terminals.freewheelStopTerminal;
      jogOk   = terminals.enableTerminal && terminals.jogModeTerminal
                && !alarmActive && terminals.freewheelStopTerminal;
      crawlOk = terminals.startRunTerminal && terminals.jogModeTerminal
                && !terminals.enableTerminal && !alarmActive
                && terminals.freewheelStopTerminal;
   end

   // Register read mux
   always_comb
   begin
      rdData = 32'h0000_0000;
      case (wb_adr_i)
         dsss_pkg::OFS_CTRL:
         begin
            rdData[dsss_pkg::CTRL_HOLD_ZERO] = s.cfg.holdZero;
            rdData[dsss_pkg::CTRL_INCH_SEL]  = s.cfg.inchSel;
            rdData[dsss_pkg::CTRL_REVERSE]   = s.cfg.reverseSel;
         end
         dsss_pkg::OFS_NRM_MS:   rdData[15:0] = s.cfg.normalMs;
         dsss_pkg::OFS_QCK_MS:   rdData[15:0] = s.cfg.quickMs;
         dsss_pkg::OFS_QCK_CAP:  rdData[15:0] = s.cfg.quickCap;
         dsss_pkg::OFS_ZERO_THR: rdData[15:0] = s.cfg.zeroThresh;
         dsss_pkg::OFS_INCH1:    rdData[15:0] = s.cfg.inch1;
         dsss_pkg::OFS_INCH2:    rdData[15:0] = s.cfg.inch2;
         dsss_pkg::OFS_CRAWL:    rdData[15:0] = s.cfg.crawl;
         dsss_pkg::OFS_RUN_SPD:  rdData[15:0] = s.cfg.runSpeed;
         dsss_pkg::OFS_HOLD_MS:  rdData[15:0] = s.cfg.holdoffMs;
         dsss_pkg::OFS_STATUS:
         begin
            rdData[8:0]   = s.state;
            rdData[9]     = s.drive.tripLatched;
            rdData[10]    = s.drive.contactorClose;
            rdData[11]    = s.drive.quench;
            rdData[12]    = s.drive.loopsInhibit;
            rdData[13]    = s.drive.reverseDir;
            rdData[20:16] = terminals;
            rdData[21]    = alarmActive;
            rdData[22]    = tripCondition;
         end
         dsss_pkg::OFS_DEMAND:   rdData[15:0] = s.drive.speedDemand;
         default:                rdData = 32'h0000_0000;
      endcase
   end

   always_comb
   begin
      next_s           = s;
      next_s.wbAck     = 1'b0;
      next_s.tripReset = 1'b0;
      rampLoad         = 1'b0;
      access           = wb_cyc_i && wb_stb_i && !s.wbAck;

      // Bus access: ack one cycle after the strobe, unmapped writes ignored
      if (access)
      begin
         next_s.wbAck = 1'b1;
         next_s.wbDat = rdData;
         if (wb_we_i)
         begin
            case (wb_adr_i)
               dsss_pkg::OFS_CTRL:
               begin
                  if (wb_sel_i[0])
                  begin
                     next_s.cfg.holdZero   = wb_dat_i[dsss_pkg::CTRL_HOLD_ZERO];
                     next_s.cfg.inchSel    = wb_dat_i[dsss_pkg::CTRL_INCH_SEL];
                     next_s.cfg.reverseSel = wb_dat_i[dsss_pkg::CTRL_REVERSE];
                     next_s.tripReset      = wb_dat_i[dsss_pkg::CTRL_TRIP_RESET];
                  end
               end
               dsss_pkg::OFS_NRM_MS:
                  next_s.cfg.normalMs = laneWrite(s.cfg.normalMs, wb_dat_i[15:0], wb_sel_i[1:0]);
               dsss_pkg::OFS_QCK_MS:
                  next_s.cfg.quickMs = laneWrite(s.cfg.quickMs, wb_dat_i[15:0], wb_sel_i[1:0]);
               dsss_pkg::OFS_QCK_CAP:
                  next_s.cfg.quickCap = laneWrite(s.cfg.quickCap, wb_dat_i[15:0], wb_sel_i[1:0]);
               dsss_pkg::OFS_ZERO_THR:
                  next_s.cfg.zeroThresh =
                     laneWrite(s.cfg.zeroThresh, wb_dat_i[15:0], wb_sel_i[1:0]);
               dsss_pkg::OFS_INCH1:
                  next_s.cfg.inch1 = laneWrite(s.cfg.inch1, wb_dat_i[15:0], wb_sel_i[1:0]);
               dsss_pkg::OFS_INCH2:
                  next_s.cfg.inch2 = laneWrite(s.cfg.inch2, wb_dat_i[15:0], wb_sel_i[1:0]);
               dsss_pkg::OFS_CRAWL:
                  next_s.cfg.crawl = laneWrite(s.cfg.crawl, wb_dat_i[15:0], wb_sel_i[1:0]);
               dsss_pkg::OFS_RUN_SPD:
                  next_s.cfg.runSpeed = laneWrite(s.cfg.runSpeed, wb_dat_i[15:0], wb_sel_i[1:0]);
               dsss_pkg::OFS_HOLD_MS:
                  next_s.cfg.holdoffMs =
                     laneWrite(s.cfg.holdoffMs, wb_dat_i[15:0], wb_sel_i[1:0]);
               default:
                  next_s.cfg = s.cfg;
            endcase
         end
      end

      // Millisecond timer shared by the stop ramps and the contactor holdoff
      if (s.msDiv == MS_LAST)
      begin
         next_s.msDiv = 16'h0000;
         if (s.msCount != 16'hffff)
            next_s.msCount = s.msCount + 16'h0001;
      end
      else
      begin
         next_s.msDiv = s.msDiv + 16'h0001;
      end

      case (s.state)
         dsss_pkg::ST_IDLE:
         begin
            if (jogOk)
               next_s.state = dsss_pkg::ST_JOG;
            else if (crawlOk)
               next_s.state = dsss_pkg::ST_CRAWL;
            else if (startOk)
               next_s.state = dsss_pkg::ST_RUN;
         end
         dsss_pkg::ST_RUN, dsss_pkg::ST_CRAWL:
         begin
            // Stop requests checked in priority order
            if (!terminals.freewheelStopTerminal
                || (s.state == dsss_pkg::ST_RUN && !terminals.enableTerminal))
               next_s.state = dsss_pkg::ST_COAST;
            else if (!terminals.controlledStopTerminal)
               next_s.state = dsss_pkg::ST_STOP_QCK;
            else if (!terminals.startRunTerminal
                     || (s.state == dsss_pkg::ST_CRAWL && !terminals.jogModeTerminal))
               next_s.state = dsss_pkg::ST_STOP_NRM;
         end
         dsss_pkg::ST_JOG:
         begin
            if (!terminals.freewheelStopTerminal)
               next_s.state = dsss_pkg::ST_COAST;
            else if (!jogOk)
               next_s.state = dsss_pkg::ST_JOG_HOLD;
         end
         dsss_pkg::ST_JOG_HOLD:
         begin
            // Contactor stays in so a rapid jog toggle does not cycle it
            if (!terminals.freewheelStopTerminal)
               next_s.state = dsss_pkg::ST_COAST;
            else if (jogOk)
               next_s.state = dsss_pkg::ST_JOG;
            else if (s.msCount >= s.cfg.holdoffMs)
               next_s.state = dsss_pkg::ST_IDLE;
         end
         dsss_pkg::ST_STOP_NRM:
         begin
            if (!terminals.freewheelStopTerminal)
               next_s.state = dsss_pkg::ST_COAST;
            else if (!terminals.controlledStopTerminal)
               next_s.state = dsss_pkg::ST_STOP_QCK;
            else if (rampAtZero)
               next_s.state = dsss_pkg::ST_IDLE;
            else if (s.msCount > s.cfg.normalMs)
               next_s.state = dsss_pkg::ST_COAST;
         end
         dsss_pkg::ST_STOP_QCK:
         begin
            if (!terminals.freewheelStopTerminal)
               next_s.state = dsss_pkg::ST_COAST;
            else if (rampAtZero)
               next_s.state = dsss_pkg::ST_IDLE;
            else if (s.msCount > s.cfg.quickMs)
               next_s.state = dsss_pkg::ST_COAST;
         end
         dsss_pkg::ST_COAST:
         begin
            // A fresh start needs the run and jog requests dropped first
            if (!terminals.startRunTerminal && !terminals.jogModeTerminal)
               next_s.state = dsss_pkg::ST_IDLE;
         end
         dsss_pkg::ST_TRIP:
         begin
            if (s.tripReset && !tripCondition)
               next_s.state = dsss_pkg::ST_IDLE;
         end
         default:
            next_s.state = dsss_pkg::ST_IDLE;
      endcase

      // Trip latch: a trip in the reset cycle wins over the reset
      if (s.state == dsss_pkg::ST_TRIP && s.tripReset && !tripCondition)
         next_s.drive.tripLatched = 1'b0;
      if (tripCondition)
      begin
         next_s.drive.tripLatched = 1'b1;
         next_s.state             = dsss_pkg::ST_TRIP;
      end

      // Restart the timer whenever a state is entered; load the ramp only on entry to a stop state
      if (next_s.state != s.state)
      begin
         next_s.msDiv   = 16'h0000;
         next_s.msCount = 16'h0000;
         if (next_s.state == dsss_pkg::ST_STOP_NRM || next_s.state == dsss_pkg::ST_STOP_QCK)
            rampLoad = 1'b1;
      end

      // Drive commands follow the next state
      next_s.drive.currentCap     = dsss_pkg::FULL_CAP;
      next_s.drive.reverseDir     = 1'b0;
      next_s.drive.quench         = 1'b1;
      next_s.drive.contactorClose = 1'b0;
      next_s.drive.speedDemand    = 16'h0000;
      case (next_s.state)
         dsss_pkg::ST_RUN:
         begin
            next_s.drive.speedDemand    = s.cfg.runSpeed;
            next_s.drive.reverseDir     = s.cfg.reverseSel;
            next_s.drive.quench         = 1'b0;
            next_s.drive.contactorClose = 1'b1;
         end
         dsss_pkg::ST_CRAWL:
         begin
            next_s.drive.speedDemand    = s.cfg.crawl;
            next_s.drive.quench         = 1'b0;
            next_s.drive.contactorClose = 1'b1;
         end
         dsss_pkg::ST_JOG:
         begin
            next_s.drive.speedDemand    = s.cfg.inchSel ? s.cfg.inch2 : s.cfg.inch1;
            next_s.drive.quench         = 1'b0;
            next_s.drive.contactorClose = 1'b1;
         end
         dsss_pkg::ST_JOG_HOLD:
         begin
            next_s.drive.quench         = 1'b0;
            next_s.drive.contactorClose = 1'b1;
         end
         dsss_pkg::ST_STOP_NRM, dsss_pkg::ST_STOP_QCK:
         begin
            // Ramp output is stale in the load cycle, so hold the demand there
            next_s.drive.speedDemand    = rampLoad ? s.drive.speedDemand : rampValue;
            next_s.drive.reverseDir     = s.drive.reverseDir;
            next_s.drive.quench         = 1'b0;
            next_s.drive.contactorClose = 1'b1;
            if (next_s.state == dsss_pkg::ST_STOP_QCK)
               next_s.drive.currentCap = s.cfg.quickCap;
         end
         default:
         begin
            // Idle, coast and trip: output quenched, contactor open
            next_s.drive.quench         = 1'b1;
            next_s.drive.contactorClose = 1'b0;
         end
      endcase

      // Standstill: loops off near zero speed while hold-at-zero is selected
      next_s.drive.loopsInhibit = s.cfg.holdZero && (measuredSpeed < s.cfg.zeroThresh);
   end

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         s                      <= '0;
         s.state                <= dsss_pkg::ST_IDLE;
         s.cfg.normalMs         <= dsss_pkg::RST_NRM_MS;
         s.cfg.quickMs          <= dsss_pkg::RST_QCK_MS;
         s.cfg.quickCap         <= dsss_pkg::RST_QCK_CAP;
         s.cfg.zeroThresh       <= dsss_pkg::RST_ZERO_THR;
         s.cfg.inch1            <= dsss_pkg::RST_INCH1;
         s.cfg.inch2            <= dsss_pkg::RST_INCH2;
         s.cfg.crawl            <= dsss_pkg::RST_CRAWL;
         s.cfg.runSpeed         <= dsss_pkg::RST_RUN_SPD;
         s.cfg.holdoffMs        <= dsss_pkg::RST_HOLD_MS;
         s.drive.currentCap     <= dsss_pkg::FULL_CAP;
         s.drive.quench         <= 1'b1;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign wb_ack_o = s.wbAck;
   assign wb_dat_o = s.wbDat;
   assign drive    = s.drive;

endmodule // dsss_sequencer
`default_nettype wire

// ==== dv/dsss_asserts.sv ====
// Timing checker for the start/stop sequencer, bound to its top module.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module dsss_asserts
(
   // Clock and reset
   input  wire logic                  sys_clk,
   input  wire logic                  reset_n,
   // Bus handshake
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_ack_o,
   // Terminals, status and commands
   input  wire dsss_pkg::dsss_term_t  terminals,
   input  wire logic                  alarmActive,
   input  wire logic                  tripCondition,
   input  wire dsss_pkg::dsss_drive_t drive
);
   wire logic en = terminals.enableTerminal;
   wire logic run = terminals.startRunTerminal;
   wire logic jog = terminals.jogModeTerminal;
   wire logic ctl = terminals.controlledStopTerminal;
   wire logic fw = terminals.freewheelStopTerminal;
   wire logic live = !drive.quench && !tripCondition;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
   sequence s_held; drive.contactorClose [*8]; endsequence
   property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> s_ack; endproperty
   property p_coast; !fw && !drive.quench |=> drive.quench && !drive.contactorClose; endproperty
   property p_trip; tripCondition |=> drive.quench && drive.tripLatched; endproperty
   property p_tripHold; drive.tripLatched && tripCondition |=> drive.tripLatched; endproperty
   property p_start; $fell(drive.quench) |-> !$past(alarmActive) && $past(fw); endproperty
   property p_run;
      $fell(drive.quench) && !$past(jog) |-> $past(en) && $past(run) && $past(ctl);
   endproperty
   property p_qcap;
      $fell(ctl) && en && fw && !jog && live && drive.speedDemand != 16'h0
         |=> drive.currentCap != dsss_pkg::FULL_CAP;
   endproperty
   // Unsigned difference also catches any rise of the demand except a rise by 16'hffff, which wraps to 1
   property p_ramp;
      en && ctl && fw && !jog && !$past(jog) && !run && live
         |=> 16'($past(drive.speedDemand) - drive.speedDemand) <= 16'h0001;
   endproperty
   property p_jogHold; $fell(jog) && en && fw && !run && live |=> s_held; endproperty
   property p_crawl; !en && !drive.quench |=> drive.quench || !drive.reverseDir; endproperty
   a_ack: assert property (p_ack) else $error("ack not a single pulse");
   a_coast: assert property (p_coast) else $error("freewheel did not coast");
   a_trip: assert property (p_trip) else $error("trip did not quench");
   a_tripHold: assert property (p_tripHold) else $error("trip cleared early");
   a_start: assert property (p_start) else $error("start while inhibited");
   a_run: assert property (p_run) else $error("run without both starts");
   a_qcap: assert property (p_qcap) else $error("quick stop not capped");
   a_ramp: assert property (p_ramp) else $error("normal stop not a ramp");
   a_jogHold: assert property (p_jogHold) else $error("contactor dropped early");
   a_crawl: assert property (p_crawl) else $error("crawl not forward");
endmodule // dsss_asserts
bind dsss_sequencer dsss_asserts u_dsssChk (.sys_clk, .reset_n, .wb_cyc_i, .wb_stb_i,
   .wb_ack_o, .terminals, .alarmActive, .tripCondition, .drive);
`default_nettype wire

// ==== dv/dsss_panel.sv ====
// Operator panel model: turns requested switch positions into terminal levels.
// Assumes requests change just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module dsss_panel
(
   // Clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 reset_n,
   // Requested positions; rude lets start through with a stop line low
   input  wire dsss_pkg::dsss_term_t want,
   input  wire logic                 rude,
   // Terminal lines, pulled low when open
   output var dsss_pkg::dsss_term_t  terminals
);
   wire logic stopsUp = rude || (terminals.controlledStopTerminal
                                 && terminals.freewheelStopTerminal);
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         terminals <= '0;
      else
      begin
         terminals <= want;
         terminals.startRunTerminal <= want.startRunTerminal && stopsUp;
      end
   end
endmodule // dsss_panel
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench for the start/stop sequencer with the panel model.
// Assumes package, design and checker bind are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checksDone++; if ((g) !== (e)) begin failCount++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module testbench;
   logic                  sys_clk = 1'b0;
   logic                  reset_n = 1'b0;
   logic                  cyc = 1'b0;
   logic                  we = 1'b0;
   logic [7:0]            adr = 8'h0;
   logic [31:0]           wdat = 32'h0;
   logic [31:0]           rdat;
   logic [31:0]           q;
   logic                  ack;
   logic                  rude = 1'b1;
   logic                  alarm = 1'b0;
   logic                  trip = 1'b0;
   logic [15:0]           spd = 16'h0;
   int                    failCount = 0;
   int                    checksDone = 0;
   int                    n;
   dsss_pkg::dsss_term_t  want = '0;
   dsss_pkg::dsss_term_t  terms;
   dsss_pkg::dsss_drive_t drive;
   logic [15:0]           rv [9] = '{dsss_pkg::RST_NRM_MS, dsss_pkg::RST_QCK_MS,
      dsss_pkg::RST_QCK_CAP, dsss_pkg::RST_ZERO_THR, dsss_pkg::RST_INCH1, dsss_pkg::RST_INCH2,
      dsss_pkg::RST_CRAWL, dsss_pkg::RST_RUN_SPD, dsss_pkg::RST_HOLD_MS};
   always #20 sys_clk = ~sys_clk;
   dsss_sequencer #(.CYC_PER_MS(10)) DUT
   (
      .sys_clk, .reset_n, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .terminals(terms),
      .alarmActive(alarm), .tripCondition(trip), .measuredSpeed(spd), .drive
   );
   dsss_panel u_panel (.sys_clk, .reset_n, .want, .rude, .terminals(terms));
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge sys_clk);
      {cyc, we, adr, wdat} <= {1'b1, w, a, d};
      do
         @(posedge sys_clk);
      while (ack !== 1'b1 && k++ < 20);
      q = rdat;
      cyc <= 1'b0;
      `CHK("ack", 1'b1, ack)
   endtask
   task automatic tm(input logic [4:0] t, input int c);
      @(posedge sys_clk);
      want <= t;
      repeat (c) @(posedge sys_clk);
   endtask
   task automatic testDone;
      $display("checks %0d errors %0d", checksDone, failCount);
      if (failCount == 0 && checksDone > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(posedge sys_clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 9; i++)
      begin
         wb(1'b0, 8'h04 + 8'(i * 4), 32'h0);
         `CHK("reset value", {16'h0, rv[i]}, q)
      end
      wb(1'b1, 8'h30, 32'h1234);
      wb(1'b0, 8'h30, 32'h0);
      `CHK("unmapped", 32'h0, q)
      $display("test registers done");
      wb(1'b1, dsss_pkg::OFS_NRM_MS, 32'h14);
      wb(1'b1, dsss_pkg::OFS_QCK_MS, 32'h4);
      wb(1'b1, dsss_pkg::OFS_RUN_SPD, 32'h40);
      wb(1'b1, dsss_pkg::OFS_HOLD_MS, 32'h3);
      tm(5'b11001, 6);
      `CHK("ctl low", 1'b1, drive.quench)
      tm(5'b10011, 6);
      `CHK("enable only", 1'b1, drive.quench)
      alarm <= 1'b1;
      rude <= 1'b0;
      tm(5'b11011, 6);
      `CHK("alarm", 1'b1, drive.quench)
      tm(5'b10011, 2);
      alarm <= 1'b0;
      tm(5'b11011, 100);
      wb(1'b0, dsss_pkg::OFS_DEMAND, 32'h0);
      `CHK("run demand", 32'h40, q)
      tm(5'b10011, 0);
      for (n = 0; drive.speedDemand !== 16'h0 && n < 400; n++)
         @(posedge sys_clk);
      `CHK("normal ramp", 1'b1, n inside {[180:215]})
      tm(5'b10011, 3);
      `CHK("normal end", 2'b01, {drive.contactorClose, drive.quench})
      tm(5'b11011, 100);
      tm(5'b10001, 4);
      `CHK("quick cap", dsss_pkg::RST_QCK_CAP, drive.currentCap)
      // Demand needs 64 cycles at one step a cycle, so only the timer ends it sooner
      for (n = 0; drive.quench !== 1'b1 && n < 100; n++)
         @(posedge sys_clk);
      `CHK("quick timer", 1'b1, n inside {[30:55]})
      tm(5'b10011, 3);
      tm(5'b11011, 100);
      tm(5'b11000, 3);
      `CHK("coast cap", dsss_pkg::FULL_CAP, drive.currentCap)
      `CHK("coast", 2'b10, {drive.quench, drive.contactorClose})
      tm(5'b00011, 3);
      tm(5'b11011, 100);
      trip <= 1'b1;
      tm(5'b11011, 3);
      `CHK("trip", 2'b11, {drive.quench, drive.tripLatched})
      wb(1'b1, dsss_pkg::OFS_CTRL, 32'h4);
      trip <= 1'b0;
      tm(5'b11011, 5);
      `CHK("trip held", 2'b11, {drive.quench, drive.tripLatched})
      tm(5'b00011, 2);
      wb(1'b1, dsss_pkg::OFS_CTRL, 32'h4);
      tm(5'b00011, 3);
      `CHK("trip reset", 1'b0, drive.tripLatched)
      wb(1'b1, dsss_pkg::OFS_CTRL, 32'h2);
      tm(5'b10111, 20);
      `CHK("inch two", dsss_pkg::RST_INCH2, drive.speedDemand)
      tm(5'b10011, 20);
      `CHK("holdoff", 1'b1, drive.contactorClose)
      tm(5'b10011, 20);
      `CHK("holdoff end", 1'b0, drive.contactorClose)
      wb(1'b1, dsss_pkg::OFS_CTRL, 32'h8);
      tm(5'b01111, 20);
      `CHK("crawl", dsss_pkg::RST_CRAWL, drive.speedDemand)
      `CHK("crawl fwd", 2'b00, {drive.reverseDir, drive.quench})
      tm(5'b00011, 230);
      wb(1'b1, dsss_pkg::OFS_CTRL, 32'h1);
      spd <= 16'h0010;
      tm(5'b00011, 3);
      `CHK("standstill", 1'b1, drive.loopsInhibit)
      spd <= 16'h0100;
      tm(5'b00011, 3);
      `CHK("moving", 1'b0, drive.loopsInhibit)
      $display("test sequencing done");
      testDone();
   end
   // About 1100 cycles expected; cut off well beyond that
   initial
   begin
      #2000000;
      failCount++;
      testDone();
   end
endmodule // testbench
`default_nettype wire
